//--- hw/flash_cmd_defs.svh
// Constants for the ID, power-down and security-register command engine.
// Assumes a 125 MHz core clock; times are in nanoseconds.
// Functional notes
// - 92h plus address returns IDs on two lines
// - Address 000001h returns device byte first
// - 94h: address, four dummy clocks, quad output
// - 9Fh shifts out three ID bytes serially
// - 9Fh not decoded while a cycle runs
// - Chip select high ends readout, standby
// - 4Bh, four dummy bytes, 64-bit unique number
// - B9h needs chip select high after bit eight
// - Power-down entered within the entry delay
// - Powered down: only ABh is recognised
// - ABh wakes after the release delay
// - ABh, three dummies, device byte repeats
// - ABh with ID uses the shorter delay
// - ABh ignored while a cycle runs
// - 48h: address, dummy byte, then serial data
// - Offset increments and wraps FFh to 00h
// - Bits 15-12 select register one to three
// - Three 256-byte registers apart from the array
// - 44h needs write enable and bit-eight end
// - Erase is self-timed, busy flag set meanwhile
// - Lock bit set makes erase ignored
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

// Opcodes
`define OP_ID_DUAL 8'h92
`define OP_ID_QUAD 8'h94
`define OP_ID_STD 8'h9F
`define OP_UNIQUE 8'h4B
`define OP_DPD 8'hB9
`define OP_RELEASE 8'hAB
`define OP_SEC_READ 8'h48
`define OP_SEC_ERASE 8'h44

// Rising-edge count at which output begins
`define START_ID_STD 7'h08
`define START_UNIQUE 7'h28
`define START_RELEASE 7'h20
`define START_SEC 7'h28
`define START_ID_DUAL 7'h14
`define START_ID_QUAD 7'h12
`define START_NEVER 7'h7F

// Rising-edge count that ends the address phase
`define ADDR_END_SINGLE 7'h20
`define ADDR_END_DUAL 7'h14
`define ADDR_END_QUAD 7'h0E
`define OPCODE_BITS 7'h08

// Security register store
`define SEC_DEPTH 768
`define SEC_ERASED 8'hFF
`define NO_DATA 8'hFF

// Timing, nanoseconds, and core clock rate
`define CORE_MHZ 125
`define T_DP_NS 3000
`define T_RES1_NS 3000
`define T_RES2_NS 1800
`define T_SE_NS 300000000

`endif

//--- hw/flash_cmd_pkg.sv
// Types used by the command engine alone; its store uses none of them.
// Assumes flash_cmd_defs.svh supplies the numeric constants.
package flash_cmd_pkg;

  // Core-side sequencing states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ENTRY = 3'b001,
    ST_DOWN = 3'b010,
    ST_RELEASE = 3'b011,
    ST_ERASE = 3'b100
  } core_state_t;

  // Status levels handed to the link side
  typedef struct packed {
    logic busy;
    logic lowPower;
  } link_stat_t;

  // Byte request handed from the link side to the store
  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] off;
  } sec_req_t;

endpackage

//--- hw/sec_reg_mem.sv
// Byte store holding the three security registers.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/1ps
`include "flash_cmd_defs.svh"
module sec_reg_mem #(
  parameter int DEPTH = 768,
  parameter int AW = 10
) (
  // Clock
  input wire logic core_clk,
  // Write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  // Read port
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData
);

  // Refuse a depth the address cannot reach
  initial
  begin
    if (DEPTH < 1 || DEPTH > (1 << AW))
      $error("sec_reg_mem: depth does not fit address width");
  end

  // Storage array
  logic [7:0] mem [DEPTH];

  // ****************************************************
  // Write and registered read
  // ****************************************************
  always_ff @(posedge core_clk)
  begin
    if (wrEn && int'(wrAddr) < DEPTH)
      mem[wrAddr] <= wrData;
  end

  always_ff @(posedge core_clk)
  begin
    if (int'(rdAddr) < DEPTH)
      rdData <= mem[rdAddr];
    else
      rdData <= `NO_DATA;
  end

endmodule

//--- hw/flash_id_cmd_engine.sv
// ID, deep power-down and security-register command engine.
// Assumes mode-0 serial timing; spiClk may stop while csN is high.
`timescale 1ns/1ps
`include "flash_cmd_defs.svh"
module flash_id_cmd_engine #(
  parameter logic [7:0] MFR_ID = 8'hA5, // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h5A, // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h18, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h3C, // Arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF, // Arbitrary
  parameter int unsigned CNT_DP = 32'((64'(`T_DP_NS) * `CORE_MHZ) / 1000),
  parameter int unsigned CNT_RES1 =
    32'((64'(`T_RES1_NS) * `CORE_MHZ + 999) / 1000),
  parameter int unsigned CNT_RES2 =
    32'((64'(`T_RES2_NS) * `CORE_MHZ + 999) / 1000),
  parameter int unsigned CNT_SE = 32'((64'(`T_SE_NS) * `CORE_MHZ) / 1000)
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Serial link
  input wire logic spiClk,
  input wire logic csN,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  // Status bits from and to the status logic
  input wire logic writeEnableLatch,
  input wire logic securityLockBit,
  output logic writeInProgressFlag,
  output logic deepPowerDownState,
  output logic welClear,
  // Security register load path
  input wire logic secWrEn,
  input wire logic [9:0] secWrAddr,
  input wire logic [7:0] secWrData
);

  // Refuse counts the sequencer cannot serve
  initial
  begin
    if (CNT_DP < 1 || CNT_RES1 < 1 || CNT_RES2 < 1)
      $error("flash_id_cmd_engine: delay counts must be at least one");
    if (CNT_SE < `SEC_DEPTH)
      $error("flash_id_cmd_engine: erase count shorter than the store");
  end

  // ****************************************************
  // Decode helpers
  // ****************************************************
  // Data lanes used after the opcode
  function automatic logic [2:0] laneCount(input logic [7:0] op);
    unique case (op)
      `OP_ID_DUAL: laneCount = 3'd2;
      `OP_ID_QUAD: laneCount = 3'd4;
      default: laneCount = 3'd1;
    endcase
  endfunction

  // Edge count at which the device starts driving
  function automatic logic [6:0] outStart(input logic [7:0] op);
    unique case (op)
      `OP_ID_STD: outStart = `START_ID_STD;
      `OP_UNIQUE: outStart = `START_UNIQUE;
      `OP_RELEASE: outStart = `START_RELEASE;
      `OP_SEC_READ: outStart = `START_SEC;
      `OP_ID_DUAL: outStart = `START_ID_DUAL;
      `OP_ID_QUAD: outStart = `START_ID_QUAD;
      default: outStart = `START_NEVER;
    endcase
  endfunction

  // Edge count that closes address capture
  function automatic logic [6:0] addrEnd(input logic [7:0] op);
    unique case (op)
      `OP_ID_DUAL: addrEnd = `ADDR_END_DUAL;
      `OP_ID_QUAD: addrEnd = `ADDR_END_QUAD;
      `OP_SEC_READ: addrEnd = `ADDR_END_SINGLE;
      default: addrEnd = `OPCODE_BITS;
    endcase
  endfunction

  // Whether the link may answer an opcode in the present state
  function automatic logic opAllowed(input logic [7:0] op,
                                     input flash_cmd_pkg::link_stat_t st);
    if (st.lowPower)
      opAllowed = (op == `OP_RELEASE) && !st.busy;
    else if (st.busy)
      opAllowed = (op != `OP_ID_STD) && (op != `OP_RELEASE);
    else
      opAllowed = 1'b1;
  endfunction

  // Byte to send for a given opcode and byte index
  function automatic logic [7:0] pickByte(input logic [7:0] op,
                                          input logic [3:0] idx,
                                          input logic swap,
                                          input logic [7:0] sec,
                                          input logic bad);
    logic [5:0] sh;
    sh = 6'(7 - idx[2:0]) << 3;
    unique case (op)
      `OP_ID_STD:
        if (idx == 4'd0)
          pickByte = MFR_ID;
        else if (idx == 4'd1)
          pickByte = MEM_TYPE;
        else if (idx == 4'd2)
          pickByte = CAPACITY;
        else
          pickByte = `NO_DATA;
      `OP_UNIQUE:
        pickByte = idx[3] ? `NO_DATA : 8'(UNIQUE_ID >> sh);
      `OP_RELEASE: pickByte = DEV_ID;
      `OP_ID_DUAL, `OP_ID_QUAD:
        pickByte = (idx[0] ^ swap) ? DEV_ID : MFR_ID;
      `OP_SEC_READ: pickByte = bad ? `NO_DATA : sec;
      default: pickByte = `NO_DATA;
    endcase
  endfunction

  // ****************************************************
  // Link side: rising-edge capture
  // ****************************************************
  logic [6:0] bitCnt_reg; // Rising edges seen in this frame
  logic [6:0] opShift_reg; // Opcode bits so far
  logic [7:0] activeOp_reg; // Opcode of this frame
  logic opOk_reg; // Link may answer this opcode
  logic [23:0] addr_reg; // Captured address
  logic [7:0] cmdCode_reg; // Last complete opcode, for the core
  logic cmdLen8_reg; // Frame held exactly eight bits so far
  flash_cmd_pkg::link_stat_t ls1_reg, ls2_reg, ls3_reg, lsHeld_reg;
  logic [7:0] opNow; // Opcode as the eighth bit lands
  logic [7:0] secByte; // Byte from the store, held stable
  logic lowPowerCore_reg; // Entering, down or releasing

  assign opNow = {opShift_reg, ioIn[0]};

  // Status levels into the link domain; held once two stages agree
  always_ff @(posedge spiClk)
  begin
    ls1_reg <= flash_cmd_pkg::link_stat_t'({writeInProgressFlag,
                                            lowPowerCore_reg});
    ls2_reg <= ls1_reg;
    ls3_reg <= ls2_reg;
    if (ls2_reg == ls3_reg)
      lsHeld_reg <= ls3_reg;
  end

  // Frame counter, opcode and address; chip select high clears all
  always_ff @(posedge spiClk or posedge csN)
  begin
    if (csN)
    begin
      bitCnt_reg <= 7'h00;
      opShift_reg <= 7'h00;
      activeOp_reg <= 8'h00;
      opOk_reg <= 1'b0;
      addr_reg <= 24'h000000;
    end
    else
    begin
      if (bitCnt_reg != 7'h7F)
        bitCnt_reg <= bitCnt_reg + 7'h01;
      if (bitCnt_reg < `OPCODE_BITS)
        opShift_reg <= opNow[6:0];
      if (bitCnt_reg == `OPCODE_BITS - 7'h01)
      begin
        activeOp_reg <= opNow;
        opOk_reg <= opAllowed(opNow, lsHeld_reg);
      end
      else if (bitCnt_reg >= `OPCODE_BITS &&
               bitCnt_reg < addrEnd(activeOp_reg))
      begin
        // Address over one, two or four lanes
        unique case (laneCount(activeOp_reg))
          3'd2: addr_reg <= {addr_reg[21:0], ioIn[1:0]};
          3'd4: addr_reg <= {addr_reg[19:0], ioIn};
          default: addr_reg <= {addr_reg[22:0], ioIn[0]};
        endcase
      end
    end
  end

  // Opcode and length kept across chip select for the core
  // Exactly eight bits marks a valid short command
  always_ff @(posedge spiClk)
  begin
    if (bitCnt_reg == `OPCODE_BITS - 7'h01)
    begin
      cmdCode_reg <= opNow;
      cmdLen8_reg <= 1'b1;
    end
    else
      cmdLen8_reg <= 1'b0;
  end

  // ****************************************************
  // Link side: falling-edge output
  // ****************************************************
  logic [7:0] shReg_reg; // Output shift register
  logic [2:0] bitPos_reg; // Clock position within the byte
  logic [3:0] byteIdx_reg; // Byte index within the readout
  logic [7:0] secOff_reg; // Security byte offset
  logic reqTog_reg; // Toggles for each store read
  flash_cmd_pkg::sec_req_t req; // Request word, stable on toggle
  logic secBad; // Address outside the three registers
  logic [7:0] curByte; // Value about to be shifted
  logic [2:0] lanes; // Output lanes for this opcode
  logic [2:0] lastPos; // Final position within a byte

  assign secBad = (addr_reg[23:16] != 8'h00) ||
                  (addr_reg[11:8] != 4'h0) ||
                  addr_reg[15:14] != 2'b00 ||
                  addr_reg[13:12] == 2'b00;
  assign req = '{sel: addr_reg[13:12], off: secOff_reg};
  assign lanes = laneCount(activeOp_reg);
  assign lastPos = 3'(8 / int'(lanes) - 1);

  // Next output byte, loaded at the first clock of each byte
  always_comb
  begin
    if (bitPos_reg == 3'd0)
      // Address bit zero swaps the ID order
      curByte = pickByte(activeOp_reg, byteIdx_reg, addr_reg[0],
                         secByte, secBad);
    else
      curByte = shReg_reg;
  end

  // Chip select high drops the drive at once
  always_ff @(negedge spiClk or posedge csN)
  begin
    if (csN)
    begin
      ioOut <= 4'h0;
      ioOe <= 4'h0;
      shReg_reg <= 8'h00;
      bitPos_reg <= 3'd0;
      byteIdx_reg <= 4'h0;
      secOff_reg <= 8'h00;
      reqTog_reg <= 1'b0;
    end
    else
    begin
      // First store read once the address is in
      if (activeOp_reg == `OP_SEC_READ && bitCnt_reg == `ADDR_END_SINGLE)
      begin
        secOff_reg <= addr_reg[7:0];
        reqTog_reg <= ~reqTog_reg;
      end
      // Shift out MSB first after the start count
      if (opOk_reg && bitCnt_reg >= outStart(activeOp_reg))
      begin
        unique case (lanes)
          3'd2:
          begin
            ioOut <= {2'b00, curByte[7:6]};
            ioOe <= 4'h3;
          end
          3'd4:
          begin
            ioOut <= curByte[7:4];
            ioOe <= 4'hF;
          end
          default:
          begin
            ioOut <= {2'b00, curByte[7], 1'b0};
            ioOe <= 4'h2;
          end
        endcase
        shReg_reg <= curByte << lanes;
        bitPos_reg <= (bitPos_reg == lastPos) ? 3'd0 : bitPos_reg + 3'd1;
        if (bitPos_reg == 3'd0)
        begin
          byteIdx_reg <= byteIdx_reg + 4'h1;
          // Offset steps and wraps within one register
          if (activeOp_reg == `OP_SEC_READ)
          begin
            secOff_reg <= secOff_reg + 8'h01;
            reqTog_reg <= ~reqTog_reg;
          end
        end
      end
    end
  end

  // ****************************************************
  // Core side: crossings from the link
  // ****************************************************
  logic cs1_reg, cs2_reg, cs3_reg, csHeld_reg;
  logic rq1_reg, rq2_reg, rq3_reg, rqHeld_reg;
  logic csRise; // Chip select has gone high
  logic rdReq; // Link asks for a store byte

  assign csRise = (cs2_reg == cs3_reg) && cs3_reg && !csHeld_reg;
  assign rdReq = (rq2_reg == rq3_reg) && (rq3_reg != rqHeld_reg);

  // Chip select and request toggle, three stages each
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      {cs1_reg, cs2_reg, cs3_reg, csHeld_reg} <= 4'hF;
      {rq1_reg, rq2_reg, rq3_reg, rqHeld_reg} <= 4'h0;
    end
    else
    begin
      {cs1_reg, cs2_reg, cs3_reg} <= {csN, cs1_reg, cs2_reg};
      {rq1_reg, rq2_reg, rq3_reg} <= {reqTog_reg, rq1_reg, rq2_reg};
      if (cs2_reg == cs3_reg)
        csHeld_reg <= cs3_reg;
      if (rq2_reg == rq3_reg)
        rqHeld_reg <= rq3_reg;
    end
  end

  // ****************************************************
  // Core side: sequencer
  // ****************************************************
  flash_cmd_pkg::core_state_t state_reg;
  logic [31:0] timer_reg; // Cycles left in the timed phase
  logic [9:0] eraseAddr_reg; // Store byte being cleared
  logic [9:0] rdAddr_reg; // Store read address
  logic memWr; // Store write strobe
  logic [9:0] memWrAddr;
  logic [7:0] memWrData;
  logic timerEnd;

  assign timerEnd = (timer_reg == 32'd1);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_reg <= flash_cmd_pkg::ST_IDLE;
      timer_reg <= 32'd0;
      writeInProgressFlag <= 1'b0;
      deepPowerDownState <= 1'b0;
      lowPowerCore_reg <= 1'b0;
      welClear <= 1'b0;
    end
    else
    begin
      welClear <= 1'b0;
      if (timer_reg != 32'd0)
        timer_reg <= timer_reg - 32'd1;
      unique case (state_reg)
        flash_cmd_pkg::ST_IDLE:
          if (csRise && cmdLen8_reg && cmdCode_reg == `OP_DPD)
          begin
            // Valid power-down starts the entry delay
            state_reg <= flash_cmd_pkg::ST_ENTRY;
            timer_reg <= CNT_DP;
            lowPowerCore_reg <= 1'b1;
          end
          // Erase needs write enable and no lock
          else if (csRise && cmdLen8_reg &&
                   cmdCode_reg == `OP_SEC_ERASE &&
                   writeEnableLatch && !securityLockBit)
          begin
            state_reg <= flash_cmd_pkg::ST_ERASE;
            timer_reg <= CNT_SE;
            writeInProgressFlag <= 1'b1;
            welClear <= 1'b1;
          end
        // Down once the entry delay runs out
        flash_cmd_pkg::ST_ENTRY:
          if (timerEnd)
          begin
            state_reg <= flash_cmd_pkg::ST_DOWN;
            deepPowerDownState <= 1'b1;
          end
        // Only the release opcode acts here
        flash_cmd_pkg::ST_DOWN:
          if (csRise && cmdCode_reg == `OP_RELEASE)
          begin
            state_reg <= flash_cmd_pkg::ST_RELEASE;
            timer_reg <= cmdLen8_reg ? CNT_RES1 : CNT_RES2;
          end
        flash_cmd_pkg::ST_RELEASE:
          if (timerEnd)
          begin
            state_reg <= flash_cmd_pkg::ST_IDLE;
            deepPowerDownState <= 1'b0;
            lowPowerCore_reg <= 1'b0;
          end
        flash_cmd_pkg::ST_ERASE:
          if (timerEnd)
          begin
            state_reg <= flash_cmd_pkg::ST_IDLE;
            writeInProgressFlag <= 1'b0;
          end
        default:
          state_reg <= flash_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // Erase walk and store read address
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      eraseAddr_reg <= 10'h000;
      rdAddr_reg <= 10'h000;
    end
    else
    begin
      if (state_reg != flash_cmd_pkg::ST_ERASE)
        eraseAddr_reg <= 10'h000;
      else if (int'(eraseAddr_reg) < `SEC_DEPTH)
        eraseAddr_reg <= eraseAddr_reg + 10'h001;
      if (rdReq)
        rdAddr_reg <= {2'(req.sel - 2'd1), req.off};
    end
  end

  // Erase writes win over the load path
  always_comb
  begin
    if (state_reg == flash_cmd_pkg::ST_ERASE &&
        int'(eraseAddr_reg) < `SEC_DEPTH)
    begin
      memWr = 1'b1;
      memWrAddr = eraseAddr_reg;
      memWrData = `SEC_ERASED;
    end
    else
    begin
      memWr = secWrEn && !securityLockBit;
      memWrAddr = secWrAddr;
      memWrData = secWrData;
    end
  end

  // Three registers in a store of their own
  sec_reg_mem #(
    .DEPTH(`SEC_DEPTH),
    .AW(10)
  ) u_store (
    .core_clk(core_clk),
    .wrEn(memWr),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddr(rdAddr_reg),
    .rdData(secByte)
  );

  // ****************************************************
  // Checks
  // ****************************************************
  a_erase_start: assert property (@(posedge core_clk) disable iff (!rstn)
    state_reg == flash_cmd_pkg::ST_IDLE && csRise && cmdLen8_reg &&
    cmdCode_reg == `OP_SEC_ERASE && writeEnableLatch && !securityLockBit
    |=> writeInProgressFlag && welClear)
    else $error("erase did not start");
  a_erase_locked: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(writeInProgressFlag) |-> !$past(securityLockBit) &&
    $past(writeEnableLatch))
    else $error("erase started while locked or not enabled");
  a_erase_ends: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(writeInProgressFlag) |-> $past(timer_reg) == 32'd1)
    else $error("busy flag cleared early");
  a_dpd_entry: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(deepPowerDownState) |->
    $past(state_reg) == flash_cmd_pkg::ST_ENTRY && $past(timer_reg) == 32'd1)
    else $error("power-down entry timing wrong");
  a_dpd_long: assert property (@(posedge core_clk) disable iff (!rstn)
    state_reg == flash_cmd_pkg::ST_IDLE && csRise && !cmdLen8_reg
    |=> state_reg == flash_cmd_pkg::ST_IDLE)
    else $error("long command acted");
  a_down_only_ab: assert property (@(posedge core_clk) disable iff (!rstn)
    state_reg == flash_cmd_pkg::ST_DOWN && csRise &&
    cmdCode_reg != `OP_RELEASE |=> state_reg == flash_cmd_pkg::ST_DOWN)
    else $error("left power-down without release");
  a_release_time: assert property (@(posedge core_clk) disable iff (!rstn)
    state_reg == flash_cmd_pkg::ST_DOWN && csRise &&
    cmdCode_reg == `OP_RELEASE
    |=> timer_reg == (cmdLen8_reg ? CNT_RES1 : CNT_RES2))
    else $error("release delay wrong");
  a_std_id_busy: assert property (@(posedge spiClk) disable iff (csN)
    bitCnt_reg == 7'h07 && lsHeld_reg.busy && opNow == `OP_ID_STD
    |=> !opOk_reg)
    else $error("standard ID decoded while busy");

endmodule

//--- sim/spi_host_model.sv
// Host controller model for the serial side of the command engine.
// Assumes mode 0; spiClk stands still while csN is high.
`timescale 1ns/1ps
module spi_host_model (
  // Link driven by the host
  output logic spiClk,
  output logic csN,
  output logic [3:0] ioIn,
  // Pins seen from the device
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe
);
  // Idle link: clock low, deselected, pulled-up lines
  initial
  begin
    spiClk = 1'b0;
    csN = 1'b1;
    ioIn = 4'hF;
  end
  // One frame: opcode, nArg argument clocks, nOut captured clocks
  task automatic frame(input logic [7:0] op, input logic [31:0] arg,
    input int nArg, input int nOut, output logic [63:0] rd,
    output logic oe);
    int i;
    int w;
    logic [3:0] pins;
    // Lanes after the opcode: two for 92h, four for 94h
    w = (op == 8'h92) ? 2 : (op == 8'h94) ? 4 : 1;
    rd = '0;
    oe = 1'b0;
    #3 csN = 1'b0;
    for (i = 0; i < 8 + nArg + nOut; i++)
    begin
      ioIn = (i < 8) ? {3'b111, op[7-i]} :
        (i < 8 + nArg) ? 4'(arg >> (w * (nArg + 7 - i))) : 4'hF;
      #32 spiClk = 1'b1;
      oe = oe | (|ioOe);
      // Undriven lines read as their pull-ups
      pins = (ioOut & ioOe) | ~ioOe;
      if (i >= 8 + nArg)
        rd = (w == 1) ? {rd[62:0], pins[1]} :
          (rd << w) | 64'(pins & 4'((1 << w) - 1));
      #32 spiClk = 1'b0;
    end
    #16 csN = 1'b1;
    // Released lines float up to their pull-ups
    ioIn = 4'hF;
  endtask
endmodule

//--- sim/tb_flash_id_cmd_engine.sv
// Self-checking bench for the ID, power-down and security engine.
// Assumes spi_host_model plays the host on the serial link.
`timescale 1ns/1ps
module tb_flash_id_cmd_engine;
  localparam logic [7:0] MFR = 8'hC1; // Arbitrary value
  localparam logic [7:0] MEMT = 8'h62; // Arbitrary value
  localparam logic [7:0] CAP = 8'h17; // Arbitrary value
  localparam logic [7:0] DEV = 8'h4E; // Arbitrary value
  localparam logic [63:0] UID = 64'hFEDC_0123_7654_89AB; // Arbitrary
  logic core_clk, rstn, spiClk, csN, writeEnableLatch, securityLockBit;
  logic writeInProgressFlag, deepPowerDownState, welClear, secWrEn, oe;
  logic [3:0] ioIn, ioOut, ioOe;
  logic [9:0] secWrAddr;
  logic [7:0] secWrData;
  logic [63:0] rd;
  int bad_count, comparisons, n, welSeen;
  flash_id_cmd_engine #(.MFR_ID(MFR), .MEM_TYPE(MEMT), .CAPACITY(CAP),
    .DEV_ID(DEV), .UNIQUE_ID(UID), .CNT_DP(20), .CNT_RES1(20),
    .CNT_RES2(12), .CNT_SE(1000)) u_flash_id_cmd_engine (
    .core_clk(core_clk), .rstn(rstn), .spiClk(spiClk), .csN(csN),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .writeEnableLatch(writeEnableLatch), .securityLockBit(securityLockBit),
    .writeInProgressFlag(writeInProgressFlag),
    .deepPowerDownState(deepPowerDownState), .welClear(welClear),
    .secWrEn(secWrEn), .secWrAddr(secWrAddr), .secWrData(secWrData));
  spi_host_model u_spi_host_model (.spiClk(spiClk), .csN(csN),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
  // Core clock, 8 ns
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Counts erase-start pulses
  always @(posedge core_clk)
    if (welClear === 1'b1)
      welSeen++;
  task automatic chk(input string what, input logic [63:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One frame, then time for csN to cross into the core
  task automatic go(input logic [7:0] op, input logic [31:0] arg,
    input int nArg, input int nOut);
    u_spi_host_model.frame(op, arg, nArg, nOut, rd, oe);
    repeat (8) @(posedge core_clk);
  endtask
  // Waits up to lim cycles for a flag to reach v
  task automatic waitFlag(input bit pd, input logic v, input int lim);
    for (n = 0; n < lim && (pd ? deepPowerDownState :
      writeInProgressFlag) !== v; n++)
      @(posedge core_clk);
    if (n >= lim)
    begin
      bad_count++;
      $display("mismatch flag wait expected %0d seen timeout", v);
      end_of_test();
    end
  endtask
  task automatic t_ids;
    go(8'h9F, 0, 0, 32);
    chk("jedec", {MFR, MEMT, CAP, 8'hFF}, rd[31:0]);
    go(8'hAB, 0, 24, 16);
    chk("devid", {DEV, DEV}, rd[15:0]);
    go(8'h4B, 0, 32, 64);
    chk("unique", UID, rd);
    go(8'h9F, 0, 0, 5);
    chk("oe end", 0, ioOe);
    go(8'h92, 0, 12, 8);
    chk("dual", {MFR, DEV}, rd[15:0]);
    go(8'h92, 1, 12, 8);
    chk("dual swap", {DEV, MFR}, rd[15:0]);
    go(8'h94, 0, 6, 8);
    chk("quad", {16'hFFFF, MFR, DEV}, rd[31:0]);
  endtask
  task automatic t_sec;
    secWrEn <= 1'b1;
    secWrAddr <= 10'h1FF;
    secWrData <= 8'h3A;
    @(posedge core_clk);
    secWrAddr <= 10'h100;
    secWrData <= 8'hC5;
    @(posedge core_clk);
    secWrEn <= 1'b0;
    go(8'h48, 32'h0020FF00, 32, 16);
    chk("sec wrap", 16'h3AC5, rd[15:0]);
    go(8'h48, 32'h0021FF00, 32, 8);
    chk("sec bad", 8'hFF, rd[7:0]);
  endtask
  task automatic t_erase;
    securityLockBit <= 1'b1;
    writeEnableLatch <= 1'b1;
    go(8'h44, 0, 0, 0);
    chk("locked", 0, writeInProgressFlag);
    securityLockBit <= 1'b0;
    go(8'h44, 0, 1, 0);
    chk("nine bits", 0, writeInProgressFlag);
    welSeen = 0;
    go(8'h44, 0, 0, 0);
    chk("busy", 1, writeInProgressFlag);
    chk("wel pulse", 1, welSeen);
    go(8'h9F, 0, 0, 32);
    chk("busy 9F", 0, oe);
    go(8'hAB, 0, 24, 8);
    chk("busy AB", 0, oe);
    waitFlag(0, 1'b0, 1200);
    chk("erase end", 0, writeInProgressFlag);
    go(8'h48, 32'h0020FF00, 32, 8);
    chk("erased", 8'hFF, rd[7:0]);
  endtask
  task automatic t_dpd;
    go(8'hB9, 0, 1, 0);
    chk("dpd nine", 0, deepPowerDownState);
    go(8'hB9, 0, 0, 0);
    waitFlag(1, 1'b1, 60);
    chk("dpd in", 1, deepPowerDownState);
    // 4Bh stands in for 9Fh here
    go(8'h4B, 0, 32, 8);
    chk("dpd deaf", 0, oe);
    go(8'hAB, 0, 0, 0);
    chk("release hold", 1, deepPowerDownState);
    waitFlag(1, 1'b0, 60);
    chk("released", 0, deepPowerDownState);
    go(8'hB9, 0, 0, 0);
    waitFlag(1, 1'b1, 60);
    go(8'hAB, 0, 24, 8);
    waitFlag(1, 1'b0, 60);
    chk("release id", 0, deepPowerDownState);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Reset for two cycles, then the scenarios
  initial
  begin
    rstn = 1'b0;
    writeEnableLatch = 1'b0;
    securityLockBit = 1'b0;
    secWrEn = 1'b0;
    secWrAddr = '0;
    secWrData = '0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_ids();
    t_sec();
    t_erase();
    t_dpd();
    end_of_test();
  end
endmodule
